/* hdl/rfst_core.sv */
// Receive and transmit byte buffers, radio state timing and carrier word, AHB-Lite slave
// What this block does
// - Two 64-byte buffers: receive and transmit
// - Flag receive overflow and transmit underflow
// - Header status gives level of accessed buffer
// - Both byte counts readable in status register
// - Store during last read duplicates that byte
// - Threshold pair: TX 61-4v, RX 4(v+1)
// - Threshold signal when count reaches threshold
// - Idle to receive: 1953 cycles plus calibration
// - Idle to transmit: 1954, or 1953 plus calibration
// - Receive/transmit switch 782, plus quarter symbol from transmit
// - Transmit to idle quarter symbol, OOK adds eighth
// - Receive to idle 2; manual calibration 283 plus calibration
// - Calibration time from test and pump settings
// - Pump enable 00b skips pump calibration
// - Carrier word from base, channel, spacing
// - Calibrate strobe in idle; results kept
// - Lock shown on pin and result register
// - Automatic calibration by configuration field
// - State changes on strobes and internal events
`timescale 1ns/100ps
module rfst_core #(
  parameter logic [19:0] CAL_09_LONG = 20'h0484A,
  parameter logic [19:0] CAL_0B_LONG = 20'h0497F,
  parameter logic [7:0] CAL_RESULT_LOCKED = 8'h20,
  parameter int FIFO_DEPTH = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic symbol_clk,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic tx_byte_take,
  output logic [7:0] tx_byte,
  input wire logic packet_done,
  output logic [7:0] status_byte,
  output logic general_output_pin
);
  // Thresholds and pointer widths assume the documented buffer size
  if (FIFO_DEPTH != rfst_pkg::FIFO_BYTES) begin : g_depth_check
    $error("rfst_core supports only 64-byte buffers");
  end

  typedef struct packed {
    rfst_pkg::rfst_radio_t st;
    rfst_pkg::rfst_radio_t tgt;
    logic [19:0] timer;
    logic cal_pend;
    logic calibrated;
    logic lock;
    logic [1:0] auto_cnt;
    logic [3:0] buffer_threshold_select;
    logic [1:0] auto_calibration_select;
    logic [2:0] power_table_index;
    logic [1:0] charge_pump_cal_enable;
    logic [7:0] calibration_test_setting;
    logic [5:0] output_pin_signal_select;
    logic [23:0] base_word;
    logic [7:0] channel_number;
    logic [7:0] spacing_mantissa;
    logic [1:0] spacing_exponent;
    logic [4:0] intermediate_freq_word;
    logic [6:0] rx_wr;
    logic [6:0] rx_rd;
    logic [6:0] tx_wr;
    logic [6:0] tx_rd;
    logic rx_ovf;
    logic tx_unf;
    logic sym_s1;
    logic sym_s2;
    logic sym_s3;
    logic [15:0] sym_cnt;
    logic [15:0] sym_per;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic [7:0] status_byte;
    logic gpo;
    logic [7:0] tx_byte;
    logic [31:0] carrier;
  } rfst_core_state_t;

  rfst_core_state_t s_q;
  rfst_core_state_t s_d;
  logic [7:0] rx_mem [0:63];
  logic [7:0] tx_mem [0:63];
  logic rx_we;
  logic tx_we;
  logic [5:0] tx_widx;

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] cal_time(input logic [7:0] test, input logic [1:0] chp);
    logic [19:0] t;
    if (chp == rfst_pkg::CHP_OFF) begin
      t = (test == rfst_pkg::TEST_SHORT) ? rfst_pkg::T_CAL_09_SHORT
                                         : rfst_pkg::T_CAL_0B_SHORT;
    end else begin
      t = (test == rfst_pkg::TEST_SHORT) ? CAL_09_LONG : CAL_0B_LONG;
    end
    return t;
  endfunction : cal_time

  always_comb begin
    logic [6:0] rx_cnt;
    logic [6:0] tx_cnt;
    logic [6:0] rx_thr;
    logic [6:0] tx_thr;
    logic rx_pop;
    logic tx_push;
    logic [4:0] cmd;
    logic go;
    rfst_pkg::rfst_radio_t go_tgt;
    logic [19:0] go_time;
    logic go_cal;
    logic auto_cal;
    logic [19:0] cal;
    logic [19:0] quarter;
    logic [19:0] eighth;
    logic [26:0] spacing;
    logic [26:0] word;
    logic addr_ok;
    s_d = s_q;
    rx_we = 1'b0;
    tx_we = 1'b0;
    tx_widx = s_q.tx_wr[5:0];
    rx_cnt = s_q.rx_wr - s_q.rx_rd;
    tx_cnt = s_q.tx_wr - s_q.tx_rd;
    rx_thr = {1'b0, s_q.buffer_threshold_select, 2'b00} + 7'h04;
    tx_thr = rfst_pkg::TX_THR_BASE - {1'b0, s_q.buffer_threshold_select, 2'b00};
    rx_pop = 1'b0;
    tx_push = 1'b0;
    cmd = 5'h00;
    go = 1'b0;
    go_tgt = rfst_pkg::RFST_IDLE;
    go_time = rfst_pkg::T_RX_IDLE;
    go_cal = 1'b0;
    cal = cal_time(s_q.calibration_test_setting, s_q.charge_pump_cal_enable);
    quarter = {6'h00, s_q.sym_per[15:2]};
    eighth = {7'h00, s_q.sym_per[15:3]};
    if (quarter == 20'h00000) begin
      quarter = 20'h00001;
    end
    auto_cal = (s_q.auto_calibration_select == rfst_pkg::AC_EVERY) ||
               ((s_q.auto_calibration_select == rfst_pkg::AC_FOURTH) &&
                (s_q.auto_cnt == 2'h3));

    // Symbol clock arrives from outside: two flops, then edge detect on the second
    s_d.sym_s1 = symbol_clk;
    s_d.sym_s2 = s_q.sym_s1;
    s_d.sym_s3 = s_q.sym_s2;
    if (s_q.sym_s2 && !s_q.sym_s3) begin
      s_d.sym_per = s_q.sym_cnt;
      s_d.sym_cnt = 16'h0001;
    end else if (s_q.sym_cnt != 16'hFFFF) begin
      s_d.sym_cnt = s_q.sym_cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus address phase: reads are answered from the state at this edge
    addr_ok = hsel && htrans[1] && hready;
    s_d.dp_valid = addr_ok;
    if (addr_ok) begin
      s_d.dp_write = hwrite;
      s_d.dp_addr = haddr[7:0];
      s_d.status_byte = {1'b0, hwrite ? tx_cnt : rx_cnt};
      if (!hwrite) begin
        case (haddr[7:0])
          rfst_pkg::REG_CMD: s_d.hrdata = 32'h00000000;
          rfst_pkg::REG_CFG: s_d.hrdata = {2'b00, s_q.output_pin_signal_select,
            s_q.calibration_test_setting, 5'h00, s_q.charge_pump_cal_enable,
            s_q.power_table_index, s_q.auto_calibration_select,
            s_q.buffer_threshold_select};
          rfst_pkg::REG_BASE: s_d.hrdata = {8'h00, s_q.base_word};
          rfst_pkg::REG_CHAN: s_d.hrdata = {3'b000, s_q.intermediate_freq_word, 6'h00,
            s_q.spacing_exponent, s_q.spacing_mantissa, s_q.channel_number};
          rfst_pkg::REG_STATUS: s_d.hrdata = {3'b000, s_q.st, s_q.lock, 5'h00,
            s_q.tx_unf, s_q.rx_ovf, 1'b0, tx_cnt, 1'b0, rx_cnt};
          rfst_pkg::REG_RXDATA: begin
            s_d.hrdata = {24'h000000, rx_mem[s_q.rx_rd[5:0]]};
            rx_pop = 1'b1;
          end
          rfst_pkg::REG_CARRIER: s_d.hrdata = s_q.carrier;
          rfst_pkg::REG_CALRES: s_d.hrdata = {24'h000000,
            s_q.lock ? CAL_RESULT_LOCKED : rfst_pkg::CAL_UNLOCKED};
          default: s_d.hrdata = 32'h00000000;
        endcase
      end
    end

    // Bus data phase: writes take hwdata now
    if (s_q.dp_valid && s_q.dp_write) begin
      case (s_q.dp_addr)
        rfst_pkg::REG_CMD: cmd = hwdata[4:0];
        rfst_pkg::REG_CFG: begin
          s_d.buffer_threshold_select = hwdata[3:0];
          s_d.auto_calibration_select = hwdata[5:4];
          s_d.power_table_index = hwdata[8:6];
          s_d.charge_pump_cal_enable = hwdata[10:9];
          s_d.calibration_test_setting = hwdata[23:16];
          s_d.output_pin_signal_select = hwdata[29:24];
        end
        // Taken at any time; a running synthesizer may misbehave, so software waits for idle
        rfst_pkg::REG_BASE: s_d.base_word = hwdata[23:0];
        rfst_pkg::REG_CHAN: begin
          s_d.channel_number = hwdata[7:0];
          s_d.spacing_mantissa = hwdata[15:8];
          s_d.spacing_exponent = hwdata[17:16];
          s_d.intermediate_freq_word = hwdata[28:24];
        end
        rfst_pkg::REG_STATUS: begin
          if (hwdata[rfst_pkg::ST_RX_OVF]) begin
            s_d.rx_ovf = 1'b0;
          end
          if (hwdata[rfst_pkg::ST_TX_UNF]) begin
            s_d.tx_unf = 1'b0;
          end
        end
        rfst_pkg::REG_TXDATA: tx_push = 1'b1;
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive buffer
    if (rx_byte_valid) begin
      if (rx_cnt == 7'(FIFO_DEPTH)) begin
        s_d.rx_ovf = 1'b1;
      end else begin
        rx_we = 1'b1;
        s_d.rx_wr = s_q.rx_wr + 7'h01;
      end
    end
    // Reading empty leaves pointers alone and returns stale data
    if (rx_pop && rx_cnt != 7'h00) begin
      if (!(rx_we && rx_cnt == 7'h01)) begin
        s_d.rx_rd = s_q.rx_rd + 7'h01;
      end
      // A store in the same cycle as the last read keeps the pointer: byte comes twice
    end

    // Transmit buffer
    if (tx_push) begin
      tx_we = 1'b1;
      if (tx_cnt != 7'(FIFO_DEPTH)) begin
        s_d.tx_wr = s_q.tx_wr + 7'h01;
      end
      // When full the byte lands on the oldest slot, so the content is corrupted
    end
    if (tx_byte_take) begin
      if (tx_cnt == 7'h00) begin
        s_d.tx_unf = 1'b1;
      end else begin
        s_d.tx_byte = tx_mem[s_q.tx_rd[5:0]];
        s_d.tx_rd = s_q.tx_rd + 7'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Radio state sequencing
    case (s_q.st)
      rfst_pkg::RFST_IDLE: begin
        if (cmd[rfst_pkg::CMD_RX]) begin
          go = 1'b1;
          go_tgt = rfst_pkg::RFST_RX;
          go_cal = (s_q.auto_calibration_select == rfst_pkg::AC_LEAVE_IDLE);
          go_time = rfst_pkg::T_IDLE_RX + (go_cal ? cal : 20'h00000);
        end else if (cmd[rfst_pkg::CMD_TX] || cmd[rfst_pkg::CMD_SYNTH_ON_FOR_TRANSMIT_STATE]) begin
          go = 1'b1;
          go_tgt = cmd[rfst_pkg::CMD_TX] ? rfst_pkg::RFST_TX : rfst_pkg::RFST_SYNTH_ON_FOR_TRANSMIT_STATE;
          go_cal = (s_q.auto_calibration_select == rfst_pkg::AC_LEAVE_IDLE);
          go_time = go_cal ? rfst_pkg::T_IDLE_RX + cal : rfst_pkg::T_IDLE_TX;
        end else if (cmd[rfst_pkg::CMD_CAL]) begin
          go = 1'b1;
          go_cal = 1'b1;
          go_time = rfst_pkg::T_MANUAL_CAL + cal;
        end
      end
      rfst_pkg::RFST_WAIT: begin
        if (cmd[rfst_pkg::CMD_IDLE]) begin
          s_d.st = rfst_pkg::RFST_IDLE;
          s_d.cal_pend = 1'b0;
        end else if (s_q.timer <= 20'h00001) begin
          s_d.st = s_q.tgt;
          if (s_q.cal_pend) begin
            s_d.calibrated = 1'b1;
            s_d.cal_pend = 1'b0;
          end
        end else begin
          s_d.timer = s_q.timer - 20'h00001;
        end
      end
      rfst_pkg::RFST_RX: begin
        go = 1'b1;
        if (cmd[rfst_pkg::CMD_IDLE]) begin
          go_time = rfst_pkg::T_RX_IDLE;
        end else if (cmd[rfst_pkg::CMD_TX] || cmd[rfst_pkg::CMD_SYNTH_ON_FOR_TRANSMIT_STATE]) begin
          go_tgt = cmd[rfst_pkg::CMD_TX] ? rfst_pkg::RFST_TX : rfst_pkg::RFST_SYNTH_ON_FOR_TRANSMIT_STATE;
          go_time = rfst_pkg::T_SWITCH;
        end else if (packet_done) begin
          go_cal = auto_cal;
          go_time = rfst_pkg::T_RX_IDLE + (auto_cal ? cal : 20'h00000);
          s_d.auto_cnt = s_q.auto_cnt + 2'h1;
        end else begin
          go = 1'b0;
        end
      end
      rfst_pkg::RFST_TX: begin
        go = 1'b1;
        go_time = quarter + ((s_q.power_table_index == rfst_pkg::PWR_OOK) ?
                             eighth : 20'h00000);
        if (cmd[rfst_pkg::CMD_RX]) begin
          go_tgt = rfst_pkg::RFST_RX;
          go_time = rfst_pkg::T_SWITCH + quarter;
        end else if (cmd[rfst_pkg::CMD_IDLE] || (tx_byte_take && tx_cnt == 7'h00)) begin
          go_cal = 1'b0;
        end else if (packet_done) begin
          go_cal = auto_cal;
          go_time = go_time + (auto_cal ? cal : 20'h00000);
          s_d.auto_cnt = s_q.auto_cnt + 2'h1;
        end else begin
          go = 1'b0;
        end
      end
      rfst_pkg::RFST_SYNTH_ON_FOR_TRANSMIT_STATE: begin
        if (cmd[rfst_pkg::CMD_TX]) begin
          s_d.st = rfst_pkg::RFST_TX;
        end else if (cmd[rfst_pkg::CMD_IDLE]) begin
          go = 1'b1;
          go_time = rfst_pkg::T_RX_IDLE;
        end
      end
      default: s_d.st = rfst_pkg::RFST_IDLE;
    endcase
    if (go) begin
      s_d.st = rfst_pkg::RFST_WAIT;
      s_d.tgt = go_tgt;
      s_d.timer = go_time;
      s_d.cal_pend = go_cal;
      if (go_cal) begin
        s_d.calibrated = 1'b0;
      end
    end

    // Lock follows a finished calibration while the synthesizer runs; low in idle and wait
    s_d.lock = s_q.calibrated && (s_q.st == rfst_pkg::RFST_RX ||
               s_q.st == rfst_pkg::RFST_TX || s_q.st == rfst_pkg::RFST_SYNTH_ON_FOR_TRANSMIT_STATE);

    // Carrier in units of a quarter of crystal/2^16, so the exponent minus two stays exact
    spacing = 27'({9'h100 + {1'b0, s_q.spacing_mantissa}}) << s_q.spacing_exponent;
    word = {1'b0, s_q.base_word, 2'b00} + 27'(spacing * {19'h00000, s_q.channel_number});
    s_d.carrier = {5'h00, word};

    case (s_q.output_pin_signal_select)
      rfst_pkg::GPO_RX_THR: s_d.gpo = (rx_cnt >= rx_thr);
      rfst_pkg::GPO_TX_THR: s_d.gpo = (tx_cnt >= tx_thr);
      rfst_pkg::GPO_LOCK: s_d.gpo = s_q.lock;
      default: s_d.gpo = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.st <= rfst_pkg::RFST_IDLE;
      s_q.tgt <= rfst_pkg::RFST_IDLE;
      s_q.buffer_threshold_select <= rfst_pkg::THR_RST;
      s_q.auto_calibration_select <= rfst_pkg::AUTOCAL_RST;
      s_q.power_table_index <= rfst_pkg::PWR_RST;
      s_q.charge_pump_cal_enable <= rfst_pkg::CHP_RST;
      s_q.calibration_test_setting <= rfst_pkg::TEST_RST;
      s_q.output_pin_signal_select <= rfst_pkg::GPO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Buffer storage has no reset; content is only meaningful behind the pointers
  always_ff @(posedge hclk) begin
    if (rx_we) begin
      rx_mem[s_q.rx_wr[5:0]] <= rx_byte;
    end
    if (tx_we) begin
      tx_mem[tx_widx] <= hwdata[7:0];
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tx_byte = s_q.tx_byte;
  assign status_byte = s_q.status_byte;
  assign general_output_pin = s_q.gpo;
endmodule : rfst_core

/* hdl/rfst_pkg.sv */
// Package of constants and types for the radio buffer and state timing block
package rfst_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_CHAN = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RXDATA = 8'h14;
  localparam logic [7:0] REG_TXDATA = 8'h18;
  localparam logic [7:0] REG_CARRIER = 8'h1C;
  localparam logic [7:0] REG_CALRES = 8'h20;
  // Command strobe bit positions
  localparam int CMD_RX = 0;
  localparam int CMD_TX = 1;
  localparam int CMD_SYNTH_ON_FOR_TRANSMIT_STATE = 2;
  localparam int CMD_IDLE = 3;
  localparam int CMD_CAL = 4;
  // Status clear bit positions
  localparam int ST_RX_OVF = 16;
  localparam int ST_TX_UNF = 17;
  // Configuration reset values and compared setting codes
  localparam logic [3:0] THR_RST = 4'h0;
  localparam logic [1:0] AUTOCAL_RST = 2'h0;
  localparam logic [2:0] PWR_RST = 3'h0;
  localparam logic [2:0] PWR_OOK = 3'h1;
  localparam logic [1:0] CHP_RST = 2'h2;
  localparam logic [1:0] CHP_OFF = 2'h0;
  localparam logic [7:0] TEST_RST = 8'h0B;
  localparam logic [7:0] TEST_SHORT = 8'h09;
  localparam logic [5:0] GPO_RST = 6'h00;
  // Output pin signal selections and unlocked calibration result
  localparam logic [5:0] GPO_RX_THR = 6'h00;
  localparam logic [5:0] GPO_TX_THR = 6'h02;
  localparam logic [5:0] GPO_LOCK = 6'h0A;
  localparam logic [7:0] CAL_UNLOCKED = 8'h3F;
  // Automatic calibration modes
  localparam logic [1:0] AC_LEAVE_IDLE = 2'h1;
  localparam logic [1:0] AC_EVERY = 2'h2;
  localparam logic [1:0] AC_FOURTH = 2'h3;
  // Crystal cycle counts of state transitions
  localparam logic [19:0] T_IDLE_RX = 20'h007A1;
  localparam logic [19:0] T_IDLE_TX = 20'h007A2;
  localparam logic [19:0] T_SWITCH = 20'h0030E;
  localparam logic [19:0] T_RX_IDLE = 20'h00002;
  localparam logic [19:0] T_MANUAL_CAL = 20'h0011B;
  localparam logic [19:0] T_CAL_09_SHORT = 20'h00EB4;
  localparam logic [19:0] T_CAL_0B_SHORT = 20'h00FE9;
  // Buffer thresholds
  localparam logic [6:0] TX_THR_BASE = 7'h3D;
  localparam int FIFO_BYTES = 64;

  typedef enum logic [4:0] {
    RFST_IDLE = 5'b00001,
    RFST_WAIT = 5'b00010,
    RFST_RX = 5'b00100,
    RFST_TX = 5'b01000,
    RFST_SYNTH_ON_FOR_TRANSMIT_STATE = 5'b10000
  } rfst_radio_t;
endpackage : rfst_pkg

/* tb/rfst_core_properties.sv */
// Port checker for the radio buffer and state timing block
`timescale 1ns/100ps
module rfst_core_chk #(
  parameter logic [7:0] CAL_RESULT_LOCKED = 8'h20,
  parameter int FIFO_DEPTH = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_byte_valid,
  input wire logic tx_byte_take,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_acc, rd_st, rd_cal, rd_cmd;
  assign rd_acc = hsel & htrans[1] & hready & !hwrite;
  assign rd_st = rd_acc & (haddr[7:0] == rfst_pkg::REG_STATUS);
  assign rd_cal = rd_acc & (haddr[7:0] == rfst_pkg::REG_CALRES);
  assign rd_cmd = rd_acc & (haddr[7:0] == rfst_pkg::REG_CMD);
  //////////////////////////////////////////////////////////////////
  property p_count_bound; status_byte <= FIFO_DEPTH; endproperty
  a_count_bound: assert property (p_count_bound) else $error("level above depth");
  property p_zero_wait; hreadyout && !hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus answer not ready okay");
  property p_hrdata_hold; !rd_acc |=> $stable(hrdata); endproperty
  a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");
  property p_tx_hold; !tx_byte_take |=> $stable(tx_byte); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved without take");
  property p_levels; rd_st |=> hrdata[6:0] <= FIFO_DEPTH && hrdata[14:8] <= FIFO_DEPTH; endproperty
  a_levels: assert property (p_levels) else $error("status level out of range");
  property p_one_state; rd_st |=> $onehot(hrdata[28:24]); endproperty
  a_one_state: assert property (p_one_state) else $error("state field not one-hot");
  property p_hdr_level; rd_st && !rx_byte_valid |=> status_byte[6:0] == hrdata[6:0]; endproperty
  a_hdr_level: assert property (p_hdr_level) else $error("header level differs");
  property p_calres;
    rd_cal |=> hrdata == 32'h0000003F || hrdata == {24'h000000, CAL_RESULT_LOCKED};
  endproperty
  a_calres: assert property (p_calres) else $error("bad calibration result");
  property p_cmd_zero; rd_cmd |=> hrdata == 32'h00000000; endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command reads non-zero");
  c_push: cover property (rx_byte_valid);
  c_take: cover property (tx_byte_take);
  c_rd_status: cover property (rd_st);
endmodule : rfst_core_chk
bind rfst_core rfst_core_chk #(.CAL_RESULT_LOCKED(CAL_RESULT_LOCKED), .FIFO_DEPTH(FIFO_DEPTH))
  chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .rx_byte_valid, .tx_byte_take, .tx_byte, .status_byte);

/* tb/rfst_radio_model.sv */
// Radio-side partner: symbol clock, received byte pushes, transmit byte takes
`timescale 1ns/100ps
module rfst_radio_model (
  input wire logic hclk,
  input wire logic sym_run,
  output logic symbol_clk,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic tx_byte_take
);
  initial begin
    symbol_clk = 1'b0;
    rx_byte = 8'h00;
    rx_byte_valid = 1'b0;
    tx_byte_take = 1'b0;
  end
  // 200 ns symbol period, held still while nothing is on air
  always #100 if (sym_run) symbol_clk = ~symbol_clk;
  // Data line flips once the strobe drops so a stale byte cannot pass as fresh
  task automatic push(input logic [7:0] b);
    rx_byte <= b;
    rx_byte_valid <= 1'b1;
    @(posedge hclk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    @(posedge hclk);
  endtask : push
  task automatic take();
    tx_byte_take <= 1'b1;
    @(posedge hclk);
    tx_byte_take <= 1'b0;
    @(posedge hclk);
  endtask : take
endmodule : rfst_radio_model

/* tb/radio_fifo_and_state_timing_tb_top.sv */
// Self-checking bench for the radio buffer and state timing block
`timescale 1ns/100ps
module radio_fifo_and_state_timing_tb_top;
  localparam int CAL_L = 40;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sym_run, symbol_clk;
  logic [31:0] haddr, hwdata, hrdata, r, base, chw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rx_byte, tx_byte, status_byte, b, lst;
  logic rx_byte_valid, tx_byte_take, general_output_pin, packet_done;
  int fails, total_checks, cyc, v, thr, t0, n;
  logic [7:0] q[$];
  logic [7:0] ra[5] = '{8'h04, 8'h10, 8'h20, 8'h00, 8'h3C};
  logic [31:0] rv[5] = '{32'h000B0400, 32'h01000000, 32'h0000003F, 32'h0, 32'h0};
  int cmds[11] = '{0, 1, 0, 3, 4, 4, 2, 3, 1, 5, 1};
  logic [4:0] sts[11] = '{5'h04, 5'h08, 5'h04, 5'h01, 5'h01, 5'h01, 5'h10, 5'h01, 5'h08, 5'h01,
    5'h08};
  int exps[11] = '{1953, 782, 782 + 8 / 4, 2, 283 + CAL_L, 283 + 3764, 1954, 2, 1954,
    8 / 4 + 8 / 8 + 3764, 1953 + 3764};
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  rfst_core #(.CAL_09_LONG(20'h00028), .CAL_0B_LONG(20'h00028)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .symbol_clk, .rx_byte, .rx_byte_valid, .tx_byte_take, .tx_byte,
    .packet_done, .status_byte, .general_output_pin
  );
  rfst_radio_model radio_u (.hclk, .sym_run, .symbol_clk, .rx_byte, .rx_byte_valid, .tx_byte_take);
  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] carrier_exp(input logic [31:0] bw, input logic [31:0] cw);
    return (bw << 2) + cw[7:0] * ((32'h100 + cw[15:8]) << cw[17:16]);
  endfunction : carrier_exp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_time(input string nm, input int exp, input int got);
    total_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      fails++;
      $display("unexpected %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_time
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    r = hrdata;
    if (k >= 50) begin
      fails++;
      end_sim();
    end
  endtask : bus
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask : settle
  task automatic measure(input int cmd, input logic [4:0] st, input int exp);
    logic seen;
    int k;
    seen = 1'b0;
    k = 0;
    if (cmd == 5) begin
      packet_done <= 1'b1;
      @(posedge hclk);
      packet_done <= 1'b0;
    end else begin
      bus(1'b1, rfst_pkg::REG_CMD, 32'h1 << cmd);
    end
    t0 = cyc;
    do begin
      bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
      seen = seen | r[25];
      k++;
    end while (!(seen && r[28:24] === st) && k < 4000);
    if (k >= 4000) begin
      fails++;
      end_sim();
    end
    chk_time("transition cycles", exp, cyc - t0 - 2);
  endtask : measure
  //////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sym_run = 1'b0;
    packet_done = 1'b0;
    cyc = 0;
    r = $urandom(32'h42E9);
    do_reset();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], r);
    end
    $display("test reset values done");
    v = $urandom % 16;
    thr = 4 * (v + 1);
    bus(1'b1, rfst_pkg::REG_CFG, 32'h000B0400 | v);
    for (int k = 1; k <= 65; k++) begin
      b = $urandom;
      if (k < 65) q.push_back(b);
      radio_u.push(b);
      settle();
      if (k == thr - 1 || k == thr) chk("rx pin", 32'(k >= thr), 32'(general_output_pin));
      @(posedge hclk);
    end
    bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
    chk("status full", 32'h01010040, r);
    bus(1'b1, rfst_pkg::REG_STATUS, 32'h00010000);
    bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
    chk("status cleared", 32'h01000040, r);
    chk("header level", 32'h40, {24'h0, status_byte});
    do begin
      lst = r[7:0];
      bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
      n++;
    end while (lst !== r[7:0] && n < 8);
    if (n >= 8) begin
      fails++;
      end_sim();
    end
    repeat (r[6:0] - 7'h01) begin
      bus(1'b0, rfst_pkg::REG_RXDATA, 32'h0);
      chk("rx byte", {24'h0, q.pop_front()}, r);
    end
    lst = q.pop_front();
    b = $urandom;
    fork
      bus(1'b0, rfst_pkg::REG_RXDATA, 32'h0);
      radio_u.push(b);
    join
    chk("last byte", {24'h0, lst}, r);
    bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
    chk("dup level", 32'h01000002, r);
    bus(1'b0, rfst_pkg::REG_RXDATA, 32'h0);
    chk("dup byte", {24'h0, lst}, r);
    bus(1'b0, rfst_pkg::REG_RXDATA, 32'h0);
    chk("new byte", {24'h0, b}, r);
    $display("test receive buffer done");
    do_reset();
    v = $urandom % 16;
    thr = 61 - 4 * v;
    bus(1'b1, rfst_pkg::REG_CFG, 32'h020B0400 | v);
    // At most 61 bytes, never past capacity
    for (int k = 1; k <= thr; k++) begin
      b = $urandom;
      q.push_back(b);
      bus(1'b1, rfst_pkg::REG_TXDATA, {24'h0, b});
      settle();
      if (k >= thr - 1) chk("tx pin", 32'(k >= thr), 32'(general_output_pin));
      @(posedge hclk);
    end
    bus(1'b1, rfst_pkg::REG_CFG, 32'h0A0B0400 | v);
    chk("header level", thr, {24'h0, status_byte});
    bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
    chk("tx level", 32'h01000000 | (thr << 8), r);
    $display("test transmit buffer done");
    sym_run <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      r = i < 5 ? 32'h0A0B0400 : i < 8 ? 32'h0A090000 : i < 10 ? 32'h0A090060 : 32'h0A090010;
      bus(1'b1, rfst_pkg::REG_CFG, r | v);
      measure(cmds[i], sts[i], exps[i]);
    end
    bus(1'b0, rfst_pkg::REG_CALRES, 32'h0);
    chk("cal result", 32'h20, r);
    settle();
    chk("lock pin", 32'h1, {31'h0, general_output_pin});
    @(posedge hclk);
    bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
    chk("tx status", 32'h08800000 | (thr << 8), r);
    repeat (thr) begin
      radio_u.take();
      @(negedge hclk);
      chk("tx byte", {24'h0, q.pop_front()}, {24'h0, tx_byte});
      @(posedge hclk);
    end
    radio_u.take();
    n = 0;
    do begin
      bus(1'b0, rfst_pkg::REG_STATUS, 32'h0);
      n++;
    end while (r[24] !== 1'b1 && n < 100);
    chk("underflow", 32'h01020000, r & 32'hFF7FFFFF);
    if (n >= 100) begin
      fails++;
      end_sim();
    end
    $display("test state timing done");
    // Frequency words are only rewritten while the radio is idle
    for (int i = 0; i < 4; i++) begin
      base = $urandom & 32'h00FFFFFF;
      chw = $urandom & 32'h1F03FFFF;
      bus(1'b1, rfst_pkg::REG_BASE, base);
      bus(1'b1, rfst_pkg::REG_CHAN, chw);
      // Carrier word is registered one cycle behind its fields
      @(posedge hclk);
      bus(1'b0, rfst_pkg::REG_CARRIER, 32'h0);
      chk("carrier", carrier_exp(base, chw), r);
    end
    $display("test carrier word done");
    end_sim();
  end
endmodule : radio_fifo_and_state_timing_tb_top
